// File: src/lia_top.sv
// level interrupt aggregator with axi4-lite register slave
// assumes pins asynchronous, timer and peripheral lines on aclk
//
// Decided for this implementation: the address map and register access over AXI4-Lite.
`timescale 1ns/10ps
module lia_top
  import lia_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // external request pins, active low
  input wire logic [7:0] irq_pin_n,
  // periodic timer
  input wire logic timer_zero,
  input wire logic timer_irq_en,
  // on-chip peripheral bus requests
  input wire logic [7:0] periph_irq,
  input wire logic [1:0] periph_sig,
  output logic [1:0] mux_phase_lines,
  // requests out
  output logic core_irq,
  output logic evt_irq
);
  typedef struct packed {
    logic [7:0] pin_s1;
    logic [7:0] pin_s2;
    logic [31:0] pend;
    logic [31:0] grp;
    logic [31:0] enable;
    logic [31:0] assign_r;
    lia_mux_t mux_mode;
    logic [1:0] phase;
    logic core_irq;
    logic [LIA_EVT_W-1:0] evt_stat;
    logic [LIA_EVT_W-1:0] evt_en;
    logic evt_irq;
    logic tmr_prev;
    logic pin_prev;
    logic aw_have;
    logic w_have;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } lia_state_t;

  // pins idle high in the sync stages, so no false edge after reset
  localparam lia_state_t LIA_RST = '{
    pin_s1: 8'hFF,
    pin_s2: 8'hFF,
    mux_mode: LIA_MUX_RST,
    awready: 1'b1,
    wready: 1'b1,
    arready: 1'b1,
    default: '0
  };

  lia_state_t q, n;
  logic [31:0] level_req;
  logic [7:0] pin_act;
  logic timer_req;

  // strobe merge of a write into an old word
  function automatic logic [31:0] lia_merge(input logic [31:0] old,
    input logic [31:0] data, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = data[8*b +: 8];
      end
    end
    return r;
  endfunction

  // level index to bus bit order and back
  function automatic logic [31:0] lia_rev(input logic [31:0] v);
    return {<<{v}};
  endfunction

  // only the second sync stage is looked at
  assign pin_act = ~q.pin_s2;
  assign timer_req = timer_zero && timer_irq_en;

  lia_level_map u_map (
    .pin_act(pin_act),
    .timer_req(timer_req),
    .per_req(periph_sig),
    .assign_reg(q.assign_r),
    .level_req(level_req)
  );

  // next state
  always_comb begin
    logic [7:0] rd_addr;
    logic [31:0] clr;
    logic [LIA_EVT_W-1:0] evt_set;
    rd_addr = s_axi_araddr;
    clr = '0;
    evt_set = '0;
    n = q;
    // pin synchroniser
    n.pin_s1 = irq_pin_n;
    n.pin_s2 = q.pin_s1;
    // select lines walk the phases of the active mode
    if (q.phase >= q.mux_mode) begin
      n.phase = 2'b00;
    end else begin
      n.phase = q.phase + 2'b01;
    end
    // capture the group matching this phase, drop unused groups
    for (int g = 0; g < 4; g++) begin
      if (2'(g) == q.phase) begin
        n.grp[8*g +: 8] = periph_irq;
      end else if (2'(g) > q.mux_mode) begin
        n.grp[8*g +: 8] = 8'h00;
      end
    end
    // pending follows sources, no latching
    n.pend = level_req | q.grp;
    // core request from enabled pending levels
    n.core_irq = |(q.pend & q.enable);
    // events
    n.tmr_prev = timer_req;
    n.pin_prev = |pin_act;
    evt_set[LIA_EVT_CORE] = n.core_irq && !q.core_irq;
    evt_set[LIA_EVT_TMR] = timer_req && !q.tmr_prev;
    evt_set[LIA_EVT_PIN] = (|pin_act) && !q.pin_prev;
    // write address and data taken in either order
    if (q.awready && s_axi_awvalid) begin
      n.aw_have = 1'b1;
      n.awaddr = s_axi_awaddr;
    end
    if (q.wready && s_axi_wvalid) begin
      n.w_have = 1'b1;
      n.wdata = s_axi_wdata;
      n.wstrb = s_axi_wstrb;
    end
    if (q.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    // write once both halves are held
    if (q.aw_have && q.w_have && !q.bvalid) begin
      n.aw_have = 1'b0;
      n.w_have = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = LIA_RESP_OKAY;
      case (q.awaddr)
        LIA_OFF_EN: begin
          n.enable = lia_rev(lia_merge(lia_rev(q.enable), q.wdata,
            q.wstrb));
        end
        LIA_OFF_ASSIGN: begin
          n.assign_r = lia_merge(q.assign_r, q.wdata, q.wstrb) &
            LIA_ASSIGN_MASK;
        end
        LIA_OFF_PCFG: begin
          if (q.wstrb[0]) begin
            n.mux_mode = lia_mux_t'(q.wdata[1:0]);
          end
        end
        LIA_OFF_EVT_CLR: begin
          clr = lia_merge('0, q.wdata, q.wstrb);
        end
        LIA_OFF_EVT_EN: begin
          if (q.wstrb[0]) begin
            n.evt_en = q.wdata[LIA_EVT_W-1:0];
          end
        end
        LIA_OFF_PEND, LIA_OFF_AND, LIA_OFF_EVT_STAT: begin
          n.bresp = LIA_RESP_OKAY;
        end
        default: begin
          n.bresp = LIA_RESP_SLVERR;
        end
      endcase
    end
    // a lowered mode restarts the phase walk at once
    if (n.phase > n.mux_mode) begin
      n.phase = 2'b00;
    end
    // sticky events, a set beats a clear in the same cycle
    n.evt_stat = (q.evt_stat & ~clr[LIA_EVT_W-1:0]) | evt_set;
    n.evt_irq = |(q.evt_stat & q.evt_en);
    // read channel
    if (q.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    if (q.arready && s_axi_arvalid) begin
      n.rvalid = 1'b1;
      n.rresp = LIA_RESP_OKAY;
      case (rd_addr)
        LIA_OFF_PEND: begin
          n.rdata = lia_rev(q.pend);
        end
        LIA_OFF_AND: begin
          n.rdata = lia_rev(q.pend & q.enable);
        end
        LIA_OFF_EN: begin
          n.rdata = lia_rev(q.enable);
        end
        LIA_OFF_ASSIGN: begin
          n.rdata = q.assign_r;
        end
        LIA_OFF_PCFG: begin
          n.rdata = {30'h0000_0000, q.mux_mode};
        end
        LIA_OFF_EVT_STAT: begin
          n.rdata = {29'h0000_0000, q.evt_stat};
        end
        LIA_OFF_EVT_EN: begin
          n.rdata = {29'h0000_0000, q.evt_en};
        end
        LIA_OFF_EVT_CLR: begin
          n.rdata = 32'h0000_0000;
        end
        default: begin
          n.rdata = 32'h0000_0000;
          n.rresp = LIA_RESP_SLVERR;
        end
      endcase
    end
    // readies held low while a transfer is owed
    n.awready = !n.aw_have && !n.bvalid;
    n.wready = !n.w_have && !n.bvalid;
    n.arready = !n.rvalid;
  end

  // state register; reset holds the phase at zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= LIA_RST;
    end else begin
      q <= n;
    end
  end

  // outputs straight from flops
  assign s_axi_awready = q.awready;
  assign s_axi_wready = q.wready;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = q.arready;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign mux_phase_lines = q.phase;
  assign core_irq = q.core_irq;
  assign evt_irq = q.evt_irq;

  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic en_wr_hit;
  assign en_wr_hit = q.aw_have && q.w_have && !q.bvalid &&
    q.awaddr == LIA_OFF_EN;

  property p_pend_track;
    aresetn |=> q.pend == $past(level_req | q.grp);
  endproperty
  a_pend_track: assert property (p_pend_track)
    else $error("pending does not track sources");

  property p_en_sw_only;
    aresetn ##1 $changed(q.enable) |-> $past(en_wr_hit);
  endproperty
  a_en_sw_only: assert property (p_en_sw_only)
    else $error("enable changed without a bus write");

  property p_core_req;
    aresetn |=> core_irq == $past(|(q.pend & q.enable));
  endproperty
  a_core_req: assert property (p_core_req)
    else $error("core request not pending and enabled");

  property p_and_read;
    (q.arready && s_axi_arvalid && s_axi_araddr == LIA_OFF_AND) |=>
      s_axi_rvalid && s_axi_rdata == lia_rev($past(q.pend & q.enable));
  endproperty
  a_and_read: assert property (p_and_read)
    else $error("and register read mismatch");

  property p_timer_lvl;
    aresetn && timer_req |=> q.pend[$past(q.assign_r[LIA_F_TMR +: 5])];
  endproperty
  a_timer_lvl: assert property (p_timer_lvl)
    else $error("timer level not pending");

  property p_pin3_lvl;
    aresetn && pin_act[3] |=> q.pend[6];
  endproperty
  a_pin3_lvl: assert property (p_pin3_lvl)
    else $error("pin 3 did not raise level 6");

  property p_phase_bound;
    q.phase <= q.mux_mode;
  endproperty
  a_phase_bound: assert property (p_phase_bound)
    else $error("phase beyond active mode");

  property p_four_cycle;
    ($past(aresetn) && q.mux_mode == LIA_MUX_FOUR &&
      $past(q.mux_mode) == LIA_MUX_FOUR) |->
      q.phase == 2'($past(q.phase) + 2'd1);
  endproperty
  a_four_cycle: assert property (p_four_cycle)
    else $error("four-to-one phase sequence broken");

  property p_capture;
    aresetn && q.phase == 2'b00 |=> q.grp[7:0] == $past(periph_irq);
  endproperty
  a_capture: assert property (p_capture)
    else $error("group zero not captured in phase zero");

  property p_en_reset;
    $rose(aresetn) |-> q.enable == '0 && q.mux_mode == LIA_MUX_RST;
  endproperty
  a_en_reset: assert property (@(posedge aclk) p_en_reset)
    else $error("enable or mux mode wrong after reset");

  // main scenarios
  c_core_rise: cover property ($rose(core_irq));
  c_phase_three: cover property (q.phase == 2'b11);
  c_en_write: cover property (en_wr_hit);
  c_evt_irq: cover property ($rose(evt_irq));
endmodule

// File: src/lia_pkg.sv
// constants, field layout and register map of the level interrupt block
// assumes an axi4-lite master and one 40 mhz system clock
package lia_pkg;
  // register byte offsets
  localparam logic [7:0] LIA_OFF_PEND = 8'h00;
  localparam logic [7:0] LIA_OFF_AND = 8'h04;
  localparam logic [7:0] LIA_OFF_EN = 8'h08;
  localparam logic [7:0] LIA_OFF_ASSIGN = 8'h0C;
  localparam logic [7:0] LIA_OFF_PCFG = 8'h10;
  localparam logic [7:0] LIA_OFF_EVT_STAT = 8'h14;
  localparam logic [7:0] LIA_OFF_EVT_CLR = 8'h18;
  localparam logic [7:0] LIA_OFF_EVT_EN = 8'h1C;
  // level field low bits, bus bit order (bus bits 31 and 15 unused)
  localparam int LIA_F_PIN0 = 26;
  localparam int LIA_F_PIN1 = 21;
  localparam int LIA_F_PIN2 = 16;
  localparam int LIA_F_PER0 = 10;
  localparam int LIA_F_PER1 = 5;
  localparam int LIA_F_TMR = 0;
  localparam logic [31:0] LIA_ASSIGN_MASK = 32'h7FFF_7FFF;
  // fixed levels of pins 3..7
  localparam logic [4:0] LIA_PIN_LVL [3:7] = '{5'h06, 5'h08, 5'h0A,
    5'h0C, 5'h0E};
  // peripheral multiplex modes
  typedef enum logic [1:0] {
    LIA_MUX_NONE = 2'b00,
    LIA_MUX_TWO = 2'b01,
    LIA_MUX_THREE = 2'b10,
    LIA_MUX_FOUR = 2'b11
  } lia_mux_t;
  localparam lia_mux_t LIA_MUX_RST = LIA_MUX_FOUR;
  // event status bits
  localparam int LIA_EVT_CORE = 0;
  localparam int LIA_EVT_TMR = 1;
  localparam int LIA_EVT_PIN = 2;
  localparam int LIA_EVT_W = 3;
  // axi responses
  localparam logic [1:0] LIA_RESP_OKAY = 2'b00;
  localparam logic [1:0] LIA_RESP_SLVERR = 2'b10;
endpackage

// File: src/lia_level_map.sv
// maps pin, timer and periph_sig requests onto the 32-bit level vector; muxed periph_irq groups are added in lia_top
// assumes pin requests already synchronised and active high
`timescale 1ns/10ps
module lia_level_map
  import lia_pkg::*;
(
  // sources
  input wire logic [7:0] pin_act,
  input wire logic timer_req,
  input wire logic [1:0] per_req,
  // level fields, bus bit order
  input wire logic [31:0] assign_reg,
  // result, index is level
  output logic [31:0] level_req
);
  logic [4:0] f_pin0, f_pin1, f_pin2, f_per0, f_per1, f_tmr;

  // field extraction
  assign f_pin0 = assign_reg[LIA_F_PIN0 +: 5];
  assign f_pin1 = assign_reg[LIA_F_PIN1 +: 5];
  assign f_pin2 = assign_reg[LIA_F_PIN2 +: 5];
  assign f_per0 = assign_reg[LIA_F_PER0 +: 5];
  assign f_per1 = assign_reg[LIA_F_PER1 +: 5];
  assign f_tmr = assign_reg[LIA_F_TMR +: 5];

  // one or-term per source per level, no ranking between them
  for (genvar k = 0; k < 32; k++) begin : g_lvl
    localparam logic [4:0] K = 5'(k);
    assign level_req[k] =
      (pin_act[0] && f_pin0 == K) ||
      (pin_act[1] && f_pin1 == K) ||
      (pin_act[2] && f_pin2 == K) ||
      (per_req[0] && f_per0 == K) ||
      (per_req[1] && f_per1 == K) ||
      (timer_req && f_tmr == K) ||
      (pin_act[3] && LIA_PIN_LVL[3] == K) ||
      (pin_act[4] && LIA_PIN_LVL[4] == K) ||
      (pin_act[5] && LIA_PIN_LVL[5] == K) ||
      (pin_act[6] && LIA_PIN_LVL[6] == K) ||
      (pin_act[7] && LIA_PIN_LVL[7] == K);
  end
endmodule

// File: verif/lia_core_model.sv
// far side model: peripheral unit on the muxed lines, and the core input
// assumes the bench holds request levels; phase lines come from the block
`timescale 1ns/10ps
module lia_core_model (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // peripheral side
  input wire logic [31:0] per_req_levels,
  input wire logic [1:0] mux_phase_lines,
  output logic [7:0] periph_irq,
  // core side
  input wire logic core_irq,
  output logic [15:0] irq_cycles
);
  // only the group named by the current phase is driven
  assign periph_irq = per_req_levels[8 * mux_phase_lines +: 8];
  // core counts cycles with its request input high, saturating
  always_ff @(posedge aclk) begin
    if (!aresetn)
      irq_cycles <= 16'h0000;
    else if (core_irq && irq_cycles != 16'hFFFF)
      irq_cycles <= irq_cycles + 16'h0001;
  end
endmodule

// File: verif/level_interrupt_aggregator_tb_top.sv
// testbench of the level interrupt block: table of rows, then hand tests
// assumes lia_pkg, lia_top and lia_core_model compiled before it
`timescale 1ns/10ps
module level_interrupt_aggregator_tb_top;
  import lia_pkg::*;
  typedef struct packed {
    logic [7:0] pin_n;
    logic tz;
    logic te;
    logic [1:0] sig;
    logic [31:0] per;
    logic [31:0] en;
    logic [31:0] lv;
  } lia_row_t;
  // pin0..2 to 1..3, periph 4 and 5, timer 31
  localparam logic [31:0] ASG = (32'h1 << LIA_F_PIN0) |
    (32'h2 << LIA_F_PIN1) | (32'h3 << LIA_F_PIN2) | (32'h4 << LIA_F_PER0) |
    (32'h5 << LIA_F_PER1) | (32'h1F << LIA_F_TMR);
  // rows: sources, enables by level, expected levels
  lia_row_t rows [7] = '{
    '{8'hFF, 1'b1, 1'b0, 2'b00, 32'h0, 32'hFFFF_FFFF, 32'h0},
    '{8'hFE, 1'b0, 1'b0, 2'b00, 32'h0, 32'h0, 32'h2},
    '{8'h07, 1'b0, 1'b0, 2'b00, 32'h0, 32'hFFFF_FFFF, 32'h5540},
    '{8'hFF, 1'b1, 1'b1, 2'b00, 32'h0, 32'hFFFF_FFFF, 32'h8000_0000},
    '{8'hFF, 1'b0, 1'b0, 2'b11, 32'h0, 32'h10, 32'h30},
    '{8'hFF, 1'b0, 1'b0, 2'b00, 32'h8000_0001, 32'h8000_0000,
      32'h8000_0001},
    '{8'hF9, 1'b0, 1'b0, 2'b00, 32'h0, 32'h8, 32'hC}};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awa = 8'h00;
  logic [7:0] ara = 8'h00;
  logic [31:0] wd = 32'h0;
  logic [3:0] ws = 4'hF;
  logic awv = 1'b0;
  logic wv = 1'b0;
  logic brdy = 1'b0;
  logic arv = 1'b0;
  logic rrdy = 1'b0;
  logic [7:0] irq_pin_n = 8'hFF;
  logic timer_zero = 1'b0;
  logic timer_irq_en = 1'b0;
  logic [1:0] periph_sig = 2'b00;
  logic [31:0] per_lv = 32'h0;
  logic [31:0] rd;
  logic [1:0] rsp;
  logic [1:0] ph;
  wire logic awr, wr, bv, arr, rv, core_irq, evt_irq;
  wire logic [1:0] br, rr, mux_phase_lines;
  wire logic [31:0] rdat;
  wire logic [7:0] periph_irq;
  wire logic [15:0] irq_cycles;
  int n_mismatch = 0;
  int samples_checked = 0;
  // 40 mhz clock
  always #12.5 aclk = ~aclk;
  lia_top uut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
    .s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv),
    .s_axi_bready(brdy), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr),
    .s_axi_rvalid(rv), .s_axi_rready(rrdy), .irq_pin_n(irq_pin_n),
    .timer_zero(timer_zero), .timer_irq_en(timer_irq_en),
    .periph_irq(periph_irq), .periph_sig(periph_sig),
    .mux_phase_lines(mux_phase_lines), .core_irq(core_irq),
    .evt_irq(evt_irq));
  lia_core_model far (
    .aclk(aclk), .aresetn(aresetn), .per_req_levels(per_lv),
    .mux_phase_lines(mux_phase_lines), .periph_irq(periph_irq),
    .core_irq(core_irq), .irq_cycles(irq_cycles));
  // level k sits on bus bit 31-k
  function automatic logic [31:0] rev(input logic [31:0] v);
    for (int i = 0; i < 32; i++) rev[i] = v[31 - i];
  endfunction
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task end_of_test();
    if (n_mismatch == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task timeout();
    n_mismatch++;
    end_of_test();
  endtask
  // one write; address and data offered together, each dropped when taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    bit done;
    done = 0;
    @(posedge aclk);
    awa <= a;
    awv <= 1'b1;
    wd <= d;
    wv <= 1'b1;
    brdy <= 1'b1;
    for (int i = 0; i < 40 && !done; i++) begin
      @(posedge aclk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wr) wv <= 1'b0;
      if (bv) begin
        brdy <= 1'b0;
        rsp = br;
        done = 1;
      end
    end
    if (!done) timeout();
  endtask
  // one read; data and response taken at the rvalid edge
  task automatic axi_rd(input logic [7:0] a);
    bit done;
    done = 0;
    @(posedge aclk);
    ara <= a;
    arv <= 1'b1;
    rrdy <= 1'b1;
    for (int i = 0; i < 40 && !done; i++) begin
      @(posedge aclk);
      if (arv && arr) arv <= 1'b0;
      if (rv) begin
        rrdy <= 1'b0;
        rd = rdat;
        rsp = rr;
        done = 1;
      end
    end
    if (!done) timeout();
  endtask
  task src(input lia_row_t r);
    @(posedge aclk);
    irq_pin_n <= r.pin_n;
    timer_zero <= r.tz;
    timer_irq_en <= r.te;
    periph_sig <= r.sig;
    per_lv <= r.per;
  endtask
  // main sequence
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    axi_wr(LIA_OFF_ASSIGN, 32'hFFFF_FFFF);
    axi_rd(LIA_OFF_ASSIGN);
    chk("assign", rd, LIA_ASSIGN_MASK);
    axi_wr(LIA_OFF_ASSIGN, ASG);
    foreach (rows[i]) begin
      axi_wr(LIA_OFF_EN, rev(rows[i].en));
      src(rows[i]);
      repeat (12) @(posedge aclk);
      axi_rd(LIA_OFF_PEND);
      chk("pend", rd, rev(rows[i].lv));
      axi_rd(LIA_OFF_AND);
      chk("and", rd, rev(rows[i].lv & rows[i].en));
      chk("core", core_irq, |(rows[i].lv & rows[i].en));
    end
    axi_rd(LIA_OFF_EN);
    chk("en_hold", rd, rev(rows[6].en));
    // each mux mode exposes only its own groups
    src('{8'hFF, 1'b0, 1'b0, 2'b00, 32'hFFFF_FFFF, 32'h0, 32'h0});
    for (int m = 0; m < 4; m++) begin
      axi_wr(LIA_OFF_PCFG, 32'(m));
      repeat (8) @(posedge aclk);
      axi_rd(LIA_OFF_PEND);
      chk("mode", rd, rev(32'hFFFF_FFFF >> (24 - 8 * m)));
    end
    // unmapped places
    axi_wr(8'h24, 32'h1);
    chk("bresp", rsp, LIA_RESP_SLVERR);
    axi_rd(8'h20);
    chk("rresp", rsp, LIA_RESP_SLVERR);
    chk("rdata", rd, 32'h0);
    // event raised, masked and cleared
    src(rows[0]);
    axi_wr(LIA_OFF_EN, 32'h0);
    axi_wr(LIA_OFF_EVT_CLR, 32'hFFFF_FFFF);
    axi_wr(LIA_OFF_EVT_EN, 32'h1 << LIA_EVT_TMR);
    src(rows[3]);
    repeat (6) @(posedge aclk);
    chk("evt_irq", evt_irq, 1'b1);
    axi_rd(LIA_OFF_EVT_STAT);
    chk("evt_stat", rd, 32'h1 << LIA_EVT_TMR);
    axi_wr(LIA_OFF_EVT_EN, 32'h0);
    repeat (2) @(posedge aclk);
    chk("evt_mask", evt_irq, 1'b0);
    axi_wr(LIA_OFF_EVT_CLR, 32'hFFFF_FFFF);
    axi_rd(LIA_OFF_EVT_STAT);
    chk("evt_clr", rd, 32'h0);
    chk("core_seen", irq_cycles != 16'h0, 1'b1);
    // reset in mid-run with enables set
    axi_wr(LIA_OFF_EN, 32'hFFFF_FFFF);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    chk("phase_rst", mux_phase_lines, 2'b00);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    for (int k = 0; k < 6; k++) begin
      ph = mux_phase_lines;
      @(posedge aclk);
      chk("phase", mux_phase_lines, 2'(ph + 2'd1));
    end
    axi_rd(LIA_OFF_EN);
    chk("en_rst", rd, 32'h0);
    axi_rd(LIA_OFF_PCFG);
    chk("mode_rst", rd, 32'h3);
    // only the still-high timer request may raise an event after reset
    axi_rd(LIA_OFF_EVT_STAT);
    chk("evt_rst", rd, 32'h1 << LIA_EVT_TMR);
    end_of_test();
  end
endmodule
